// ---- logic/pfs_sequencer.sv ----
// Program flow sequencer: program counter, return stack and flag updates.
`timescale 1ns/10ps
`include "pfs_cfg.svh"

// Notes on behaviour
// - Absolute jump loads the 24-bit immediate target.
// - Flow changes after two delay-slot instructions.
// - Relative target is offset plus address plus two.
// - Register jump uses jump target register, both modes.
// - Data field sets or clears selected flags.
// - Interrupt target from table bits and pending interrupt.
// - Interrupt target forces bit two to one.
// - Interrupt jump is absolute and never pushes.
// - Continue advances the counter by one.
// - Call pushes counter plus one, then redirects.
// - Register call is a call via register.
// - Interrupt call pushes, then jumps absolutely.
// - Push stores jump target register, flow unchanged.
// - Return pops top entry into the counter.
// - Pop moves top entry into jump target register.
// - Counter leads executed instruction by two cycles.
module pfs_sequencer
	import pfs_pkg::*;
#(
	parameter int DEPTH = `PFS_STACK_DEPTH
) (
	// Clock and reset.
	input  wire logic                          mclk_in,
	input  wire logic                          reset_in,
	// Executed instruction from the pipeline.
	input  wire logic                          exec_in,
	input  wire pfs_instr_t                    instr_in,
	input  wire logic                          cond_in,
	// Interrupt table base and pending interrupt level and vector.
	input  wire logic [`PFS_ISR_BASE_W-1:0]    isr_base_in,
	input  wire logic [`PFS_ISR_LOW_W-1:0]     isr_low_in,
	// Load port of the jump target register.
	input  wire logic                          jtr_wr_in,
	input  wire logic [`PFS_ADDR_W-1:0]        jtr_data_in,
	// Fetch address and register state.
	output logic [`PFS_ADDR_W-1:0]             pc_out,
	output logic [`PFS_ADDR_W-1:0]             jump_target_out,
	output pfs_flag_upd_t                      flag_upd_out,
	output logic [$clog2(DEPTH+1)-1:0]         stack_depth_out,
	output logic                               stack_err_out
);

	// ************************************************************
	// Declarations
	// ************************************************************
	localparam int IDXW = $clog2(DEPTH);
	localparam int SPW  = $clog2(DEPTH+1);

	logic [`PFS_ADDR_W-1:0]  pc;              // Fetch address.
	logic [`PFS_ADDR_W-1:0]  jump_target_reg; // Register jump source.
	logic [SPW-1:0]          sp;              // Number of stored entries.
	logic [`PFS_ADDR_W-1:0]  stack_mem [DEPTH]; // Return stack words.
	pfs_flag_upd_t           flag_upd;        // Registered flag update.
	logic                    stack_err;       // Registered misuse pulse.

	// ************************************************************
	// Decode
	// ************************************************************
	// The counter is two ahead of the executed instruction, so the
	// last delay slot sits at pc and pc plus offset is the relative
	// target without any extra adder.
	wire pfs_op_t  op         = instr_in.op;
	wire logic     cond_pass  = (instr_in.cond == PFS_ALWAYS) ||
		((instr_in.cond == PFS_IF_TRUE) && cond_in) ||
		((instr_in.cond == PFS_IF_FALSE) && !cond_in);
	wire logic     take       = exec_in && cond_pass;
	wire logic     is_imm     = (op == PFS_JUMP) || (op == PFS_CALL);
	wire logic     is_reg     = (op == PFS_JUMP_REG) ||
		(op == PFS_CALL_REG);
	wire logic     is_int     = (op == PFS_JUMP_INT) ||
		(op == PFS_CALL_INT);
	wire logic     is_call    = (op == PFS_CALL) ||
		(op == PFS_CALL_REG) || (op == PFS_CALL_INT);
	wire logic     is_jump    = is_imm || is_reg || is_int;
	wire logic     wants_push = is_call || (op == PFS_PUSH);
	wire logic     wants_pop  = (op == PFS_RETURN) || (op == PFS_POP);
	wire logic     full       = (sp == SPW'(DEPTH));
	wire logic     empty      = (sp == '0);

	// Interrupt entry: table bits above, pending level and vector
	// below, software entry bit forced high.
	wire logic [`PFS_ADDR_W-1:0] isr_target =
		{isr_base_in, isr_low_in} |
		(`PFS_ADDR_W'(1) << `PFS_SW_ENTRY_BIT);

	// Target source: immediate, register or interrupt table.
	wire logic [`PFS_ADDR_W-1:0] src =
		is_imm ? instr_in.data :
		is_reg ? jump_target_reg : isr_target;

	// Interrupt forms ignore the relative bit.
	wire logic                   rel_ok = instr_in.relative && !is_int;
	wire logic [`PFS_ADDR_W-1:0] flow_target = rel_ok ?
		`PFS_ADDR_W'(pc + src) : src;
	wire logic [`PFS_ADDR_W-1:0] pc_inc = `PFS_ADDR_W'(pc + `PFS_PC_STEP);

	wire logic [IDXW-1:0]        top_idx = IDXW'(sp - SPW'(1));
	wire logic [`PFS_ADDR_W-1:0] stack_top_entry = stack_mem[top_idx];

	// A call on a full stack is refused whole, so the flow stays
	// linear and no return address is lost silently.
	wire logic do_push = take && wants_push && !full;
	wire logic do_pop  = take && wants_pop && !empty;
	wire logic do_jump = take && is_jump && (!is_call || !full);
	wire logic do_ret  = do_pop && (op == PFS_RETURN);

	// Calls push the return address, push stores the register.
	wire logic [`PFS_ADDR_W-1:0] push_val = (op == PFS_PUSH) ?
		jump_target_reg : pc_inc;

	// Next counter: hold on stall, redirect, else step by one.
	// A failed condition falls through to the step.
	wire logic [`PFS_ADDR_W-1:0] next_pc =
		!exec_in ? pc :
		do_ret   ? stack_top_entry :
		do_jump  ? flow_target : pc_inc;

	// Pop wins over an external load in the same cycle.
	wire logic [`PFS_ADDR_W-1:0] next_jtr =
		(do_pop && (op == PFS_POP)) ? stack_top_entry :
		jtr_wr_in ? jtr_data_in : jump_target_reg;

	wire logic [SPW-1:0] next_sp = do_push ? SPW'(sp + SPW'(1)) :
		do_pop ? SPW'(sp - SPW'(1)) : sp;

	// Flag update rides along with any taken operation.
	pfs_flag_upd_t next_flag_upd;
	assign next_flag_upd.we = take &&
		(instr_in.flag_op != PFS_FLAGS_NONE);
	assign next_flag_upd.set_mask = (take &&
		(instr_in.flag_op == PFS_FLAGS_SET)) ? instr_in.data : '0;
	assign next_flag_upd.clr_mask = (take &&
		(instr_in.flag_op == PFS_FLAGS_CLEAR)) ? instr_in.data : '0;

	wire logic next_stack_err = take &&
		((wants_push && full) || (wants_pop && empty));

	// ************************************************************
	// State
	// ************************************************************
	// Counter, register, pointer and output pulses.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			pc              <= `PFS_PC_RESET;
			jump_target_reg <= `PFS_JTR_RESET;
			sp              <= '0;
			flag_upd        <= '0;
			stack_err       <= 1'b0;
		end else begin
			pc              <= next_pc;
			jump_target_reg <= next_jtr;
			sp              <= next_sp;
			flag_upd        <= next_flag_upd;
			stack_err       <= next_stack_err;
		end
	end

	// Stack words need no reset; the pointer guards every read.
	always_ff @(posedge mclk_in) begin
		if (do_push) begin
			stack_mem[sp[IDXW-1:0]] <= push_val;
		end
	end

	assign pc_out          = pc;
	assign jump_target_out = jump_target_reg;
	assign flag_upd_out    = flag_upd;
	assign stack_depth_out = sp;
	assign stack_err_out   = stack_err;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	wire logic quiet = !exec_in;

	// Redirect, then an executed delay slot that changes no flow.
	// The counter must hold the target, then step from it. Each step
	// reads its reference through $past, one cycle back.
	sequence s_redirect;
		do_jump && !do_ret;
	endsequence
	sequence s_slot;
		exec_in && !do_jump && !do_ret;
	endsequence
	sequence s_land;
		(pc == $past(flow_target)) ##1
		(pc == `PFS_ADDR_W'($past(pc) + `PFS_PC_STEP));
	endsequence

	chk_abs_jump_load: assert property (
		(take && op == PFS_JUMP && !instr_in.relative) |=>
		pc == $past(instr_in.data))
		else $error("absolute jump target not loaded");
	chk_rel_target: assert property (
		(do_jump && rel_ok) |=>
		pc == `PFS_ADDR_W'($past(pc) + $past(src)))
		else $error("relative target wrong");
	chk_delay_slots: assert property (
		(s_redirect ##1 s_slot) |-> s_land)
		else $error("redirect not followed by linear fetch");
	chk_reg_source: assert property (
		(do_jump && is_reg && !rel_ok) |=>
		pc == $past(jump_target_reg))
		else $error("register jump target wrong");
	chk_int_entry: assert property (
		(do_jump && is_int) |=> (pc[`PFS_SW_ENTRY_BIT] == 1'b1) &&
		(pc[`PFS_ADDR_W-1:`PFS_ISR_LOW_W] == $past(isr_base_in)))
		else $error("interrupt entry address wrong");
	chk_int_no_push: assert property (
		(take && op == PFS_JUMP_INT) |=> $stable(sp))
		else $error("interrupt jump changed stack");
	chk_call_push: assert property (
		(do_push && is_call) |=> (sp == SPW'($past(sp) + SPW'(1))) &&
		(stack_top_entry == `PFS_ADDR_W'($past(pc) + `PFS_PC_STEP)))
		else $error("call did not push return address");
	chk_push_keeps_flow: assert property (
		(take && op == PFS_PUSH) |=>
		pc == `PFS_ADDR_W'($past(pc) + `PFS_PC_STEP))
		else $error("push changed flow");
	chk_return_pop: assert property (
		do_ret |=> (pc == $past(stack_top_entry)) &&
		(sp == SPW'($past(sp) - SPW'(1))))
		else $error("return did not pop");
	chk_pop_to_reg: assert property (
		(do_pop && op == PFS_POP) |=>
		jump_target_reg == $past(stack_top_entry))
		else $error("pop did not load register");
	chk_flag_update: assert property (
		(take && instr_in.flag_op == PFS_FLAGS_SET) |=>
		flag_upd_out.we && (flag_upd_out.set_mask == $past(instr_in.data)))
		else $error("flag set not issued");
	chk_cond_fail: assert property (
		(exec_in && !cond_pass) |=> $stable(sp) && !flag_upd_out.we &&
		(pc == `PFS_ADDR_W'($past(pc) + `PFS_PC_STEP)))
		else $error("failed condition changed state");
	chk_stall_hold: assert property (
		quiet |=> $stable(pc) && $stable(sp))
		else $error("counter moved during stall");

endmodule // pfs_sequencer

// ---- shared/pfs_cfg.svh ----
// Constants of the program flow sequencer.
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// Width of the program counter and of every address word.
`define PFS_ADDR_W        24
// Width of the interrupt table base field.
`define PFS_ISR_BASE_W    16
// Width of the pending interrupt level and vector field.
`define PFS_ISR_LOW_W     8
// Position of the bit that selects the software entry.
`define PFS_SW_ENTRY_BIT  2
// Depth of the internal return stack.
`define PFS_STACK_DEPTH   8
// Reset value of the program counter.
`define PFS_PC_RESET      24'h000000
// Reset value of the jump target register.
`define PFS_JTR_RESET     24'h000000
// Step of the program counter on a plain advance.
`define PFS_PC_STEP       24'h000001

`endif

// ---- shared/pfs_pkg.sv ----
// Types of the program flow sequencer.
`include "pfs_cfg.svh"

package pfs_pkg;

	// Control flow operations carried by the sequencer field.
	typedef enum logic [3:0] {
		PFS_CONTINUE,
		PFS_JUMP,
		PFS_JUMP_REG,
		PFS_JUMP_INT,
		PFS_CALL,
		PFS_CALL_REG,
		PFS_CALL_INT,
		PFS_PUSH,
		PFS_RETURN,
		PFS_POP
	} pfs_op_t;

	// How the selected condition gates the operation.
	typedef enum logic [1:0] {
		PFS_ALWAYS,
		PFS_IF_TRUE,
		PFS_IF_FALSE
	} pfs_cond_t;

	// What the data field does to the status and control flags.
	typedef enum logic [1:0] {
		PFS_FLAGS_NONE,
		PFS_FLAGS_SET,
		PFS_FLAGS_CLEAR
	} pfs_flag_op_t;

	// One decoded sequencer instruction.
	typedef struct packed {
		pfs_op_t                   op;
		logic                      relative;
		pfs_cond_t                 cond;
		pfs_flag_op_t              flag_op;
		logic [`PFS_ADDR_W-1:0]    data;
	} pfs_instr_t;

	// Flag update sent to the status and control register.
	typedef struct packed {
		logic                      we;
		logic [`PFS_ADDR_W-1:0]    set_mask;
		logic [`PFS_ADDR_W-1:0]    clr_mask;
	} pfs_flag_upd_t;

endpackage

// ---- verif/pfs_fetch_model.sv ----
// Model of the fetch pipeline that sits between the program counter and execute.
`timescale 1ns/10ps

module pfs_fetch_model (
	// Clock and reset.
	input  wire logic        mclk_in,
	input  wire logic        reset_in,
	// Fetch address and pipeline advance.
	input  wire logic        adv_in,
	input  wire logic [23:0] pc_in,
	// Address of the instruction now executed.
	output logic      [23:0] exec_addr_out
);
	logic [23:0] fetch_addr;  // Address held in the cache stage.

	// Two stages between fetch and execute; a stall freezes both.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			fetch_addr    <= 24'h000000;
			exec_addr_out <= 24'h000000;
		end else if (adv_in) begin
			fetch_addr    <= pc_in;
			exec_addr_out <= fetch_addr;
		end
	end
endmodule // pfs_fetch_model

// ---- verif/tb_program_flow_sequencer.sv ----
// Self-checking testbench of the program flow sequencer.
`timescale 1ns/10ps

module tb_program_flow_sequencer;
	import pfs_pkg::*;

	// ****
	// Signals
	// ****
	logic          mclk_in = 1'b0;
	logic          reset_in = 1'b1;
	logic          exec_in = 1'b0;
	pfs_instr_t    instr_in = '0;
	logic          cond_in = 1'b0;
	logic [15:0]   isr_base_in = 16'h0000;
	logic [7:0]    isr_low_in = 8'h00;
	logic          jtr_wr_in = 1'b0;
	logic [23:0]   jtr_data_in = 24'h000000;
	logic [23:0]   pc_out;
	logic [23:0]   jump_target_out;
	logic [23:0]   exec_addr;  // Executed address seen by the model.
	pfs_flag_upd_t flag_upd_out;
	logic [3:0]    stack_depth_out;
	logic          stack_err_out;
	int            num_errors = 0;
	int            comparisons = 0;

	// Clock of 5 ns.
	always #2.5 mclk_in = ~mclk_in;

	pfs_sequencer dut_u (.mclk_in(mclk_in), .reset_in(reset_in),
		.exec_in(exec_in), .instr_in(instr_in), .cond_in(cond_in),
		.isr_base_in(isr_base_in), .isr_low_in(isr_low_in),
		.jtr_wr_in(jtr_wr_in), .jtr_data_in(jtr_data_in),
		.pc_out(pc_out), .jump_target_out(jump_target_out),
		.flag_upd_out(flag_upd_out), .stack_depth_out(stack_depth_out),
		.stack_err_out(stack_err_out));

	pfs_fetch_model fetch_u (.mclk_in(mclk_in), .reset_in(reset_in),
		.adv_in(exec_in), .pc_in(pc_out), .exec_addr_out(exec_addr));

	// ****
	// Shared tasks
	// ****
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One instruction for one cycle, then a stall so counter, register and depth stand still.
	task automatic issue(input pfs_op_t op, input logic rel,
		input pfs_cond_t cd, input pfs_flag_op_t fo, input logic [23:0] d);
		@(negedge mclk_in);
		instr_in = '{op, rel, cd, fo, d};
		exec_in = 1'b1;
		@(negedge mclk_in);
		exec_in = 1'b0;
	endtask

	task automatic go(input pfs_op_t op, input logic rel,
		input logic [23:0] d);
		issue(op, rel, PFS_ALWAYS, PFS_FLAGS_NONE, d);
	endtask

	task automatic load_jtr(input logic [23:0] d);
		@(negedge mclk_in);
		jtr_wr_in = 1'b1;
		jtr_data_in = d;
		@(negedge mclk_in);
		jtr_wr_in = 1'b0;
		check(jump_target_out, d);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_jump();
		repeat (3) go(PFS_CONTINUE, 1'b0, 24'h0);
		// Jump with its first delay slot right behind it; the slots
		// carry no flow change.
		@(negedge mclk_in);
		instr_in = '{PFS_JUMP, 1'b0, PFS_ALWAYS, PFS_FLAGS_NONE,
			24'h123456};
		exec_in = 1'b1;
		@(negedge mclk_in);
		check(pc_out, 24'h123456);
		instr_in = '{PFS_CONTINUE, 1'b0, PFS_ALWAYS, PFS_FLAGS_NONE,
			24'h0};
		@(negedge mclk_in);
		exec_in = 1'b0;
		check(exec_addr, 24'h000003);
		check(pc_out, 24'h123457);
		go(PFS_CONTINUE, 1'b0, 24'h0);
		check(exec_addr, 24'h123456);
		check(pc_out, 24'h123458);
	endtask

	task automatic t_rel();
		go(PFS_JUMP, 1'b1, 24'hfffff0);
		check(pc_out, 24'h123448);
		load_jtr(24'h000100);
		go(PFS_JUMP_REG, 1'b1, 24'h0);
		check(pc_out, 24'h123548);
		go(PFS_JUMP_REG, 1'b0, 24'h0);
		check(pc_out, 24'h000100);
	endtask

	// Nesting stays at three levels.
	task automatic t_call();
		go(PFS_CALL, 1'b0, 24'h004000);
		go(PFS_CALL_REG, 1'b1, 24'h0);
		check(pc_out, 24'h004100);
		isr_base_in = 16'habcd;
		isr_low_in = 8'h30;
		go(PFS_CALL_INT, 1'b1, 24'h0);
		check(pc_out, 24'habcd34);
		check(24'(stack_depth_out), 24'h3);
		isr_low_in = 8'h41;
		go(PFS_JUMP_INT, 1'b1, 24'h0);
		check(pc_out, 24'habcd45);
		check(24'(stack_depth_out), 24'h3);
		go(PFS_POP, 1'b0, 24'h0);
		check(jump_target_out, 24'h004101);
		check(pc_out, 24'habcd46);
		go(PFS_RETURN, 1'b0, 24'h0);
		check(pc_out, 24'h004001);
		go(PFS_RETURN, 1'b0, 24'h0);
		check(pc_out, 24'h000101);
		go(PFS_PUSH, 1'b0, 24'h0);
		check(pc_out, 24'h000102);
		// Leaving the interrupt routine clears its mask flag.
		issue(PFS_RETURN, 1'b0, PFS_ALWAYS, PFS_FLAGS_CLEAR, 24'h000010);
		check(pc_out, 24'h004101);
		check(flag_upd_out.clr_mask, 24'h000010);
	endtask

	task automatic t_cond();
		issue(PFS_JUMP, 1'b0, PFS_IF_TRUE, PFS_FLAGS_SET, 24'h000055);
		check(pc_out, 24'h004102);
		check(24'(flag_upd_out.we), 24'h0);
		issue(PFS_CALL, 1'b0, PFS_IF_FALSE, PFS_FLAGS_NONE, 24'h000200);
		check(pc_out, 24'h000200);
		cond_in = 1'b1;
		issue(PFS_RETURN, 1'b0, PFS_IF_FALSE, PFS_FLAGS_NONE, 24'h0);
		check(24'(stack_depth_out), 24'h1);
		issue(PFS_RETURN, 1'b0, PFS_IF_TRUE, PFS_FLAGS_NONE, 24'h0);
		check(pc_out, 24'h004103);
	endtask

	task automatic t_flags();
		issue(PFS_CONTINUE, 1'b0, PFS_ALWAYS, PFS_FLAGS_SET, 24'h0000a5);
		check(24'(flag_upd_out.we), 24'h1);
		check(flag_upd_out.set_mask, 24'h0000a5);
		issue(PFS_PUSH, 1'b0, PFS_ALWAYS, PFS_FLAGS_CLEAR, 24'h000300);
		check(flag_upd_out.clr_mask, 24'h000300);
		check(flag_upd_out.set_mask, 24'h0);
		go(PFS_POP, 1'b0, 24'h0);
	endtask

	// Fills the stack until it refuses, then drains it past empty.
	task automatic t_full();
		repeat (8) go(PFS_PUSH, 1'b0, 24'h0);
		check(24'(stack_depth_out), 24'h8);
		go(PFS_CALL, 1'b0, 24'h0);
		check(24'(stack_err_out), 24'h1);
		check(24'(stack_depth_out), 24'h8);
		repeat (8) go(PFS_POP, 1'b0, 24'h0);
		go(PFS_RETURN, 1'b0, 24'h0);
		check(24'(stack_err_out), 24'h1);
	endtask

	// ****
	// Run control
	// ****
	task automatic test_done();
		$display("Checks %0d, errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge mclk_in);
		@(negedge mclk_in);
		reset_in = 1'b0;
		t_jump();
		t_rel();
		t_call();
		t_cond();
		t_flags();
		t_full();
		test_done();
	end

	// The run needs some 90 cycles; 2000 cycles means a hang.
	initial begin
		#10000;
		num_errors++;
		test_done();
	end
endmodule // tb_program_flow_sequencer
